// File: adcmc_pkg.sv
// Constants, state types and carrier structs for the converter mode control block.
package adcmc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned WAKE_NS = 25_000;
  localparam int unsigned WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TOUT_MS = 25;
  localparam int unsigned TOUT_CYC_DEF = TOUT_MS * (CLK_HZ / 1000) + 1;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned RATES = 8;
  localparam int unsigned CONV_CYC_DEF [RATES] = '{CLK_HZ / 128, CLK_HZ / 250, CLK_HZ / 490, CLK_HZ / 920,
                                                   CLK_HZ / 1600, CLK_HZ / 2400, CLK_HZ / 3300, CLK_HZ / 3300};

  // ****************************************************************
  // Configuration word layout and bus codes
  // ****************************************************************
  localparam int unsigned CFG_OS = 15;
  localparam int unsigned CFG_MODE = 8;
  localparam int unsigned DR_LSB = 5;
  localparam int unsigned DR_W = 3;
  localparam logic [15:0] CFG_DEF = 16'h8583;
  localparam int unsigned RES_W = 12;
  localparam logic [3:0] RES_PAD = 4'h0;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RST_CMD = 8'h06;
  localparam logic [1:0] PTR_CONV = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [4:0] {
    SL_IDLE = 5'h01, SL_ADDR = 5'h02, SL_ACK = 5'h04, SL_RX = 5'h08, SL_TX = 5'h10
  } adcmc_sl_e;
  localparam adcmc_sl_e SL_MACK_ST = SL_TX;

  typedef enum logic [2:0] {
    CV_IDLE = 3'h1, CV_WAKE = 3'h2, CV_CONV = 3'h4
  } adcmc_cv_e;

  typedef struct packed {
    logic soft_rst;
    logic os_req;
    logic [15:0] cfg;
  } adcmc_req_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [15:0] result;
    logic [15:0] act_cfg;
  } adcmc_rsp_s;

endpackage

// File: adcmc_conv.sv
// Conversion sequencer: power-down, wake-up, single-shot and continuous timing.
`timescale 1ns/1ps
module adcmc_conv import adcmc_pkg::*; #(
  parameter int unsigned CONV_CYC [RATES] = CONV_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire adcmc_req_s req,
  input wire logic [RES_W-1:0] conv_data,
  output adcmc_rsp_s rsp
);

  typedef struct packed {
    adcmc_cv_e st;
    logic [CNT_W-1:0] cnt;
    logic [15:0] act;
    logic [15:0] res;
    logic done;
    logic [RES_W-1:0] d1;
    logic [RES_W-1:0] d2;
  } adcmc_cv_s;

  adcmc_cv_s r;
  adcmc_cv_s n;
  logic single;
  logic [CNT_W-1:0] conv_last;

  // Refuse conversion periods the counter cannot hold.
  for (genvar g = 0; g < RATES; g++) begin : g_chk
    if (CONV_CYC[g] < 2 || CONV_CYC[g] >= (1 << CNT_W)) begin : g_bad
      $error("conversion period out of range");
    end
  end

  // Live mode bit and the period of the conversion in progress.
  assign single = req.cfg[CFG_MODE];
  assign conv_last = CNT_W'(CONV_CYC[r.act[DR_LSB +: DR_W]] - 1);

  // Next state of the sequencer.
  always_comb begin
    n = r;
    n.done = 1'h0;
    n.d1 = conv_data;
    n.d2 = r.d1;
    n.cnt = r.cnt + 1'h1;
    case (r.st)
      CV_IDLE: begin
        n.cnt = '0;
        if (!single || req.os_req) begin
          n.st = CV_WAKE;
        end
      end
      CV_WAKE: begin
        if (r.cnt == CNT_W'(WAKE_CYC - 1)) begin
          n.st = CV_CONV;
          n.cnt = '0;
          n.act = req.cfg;
        end
      end
      CV_CONV: begin
        if (r.cnt == conv_last) begin
          n.done = 1'h1;
          n.res = {r.d2, RES_PAD};
          n.cnt = '0;
          // settings taken at each conversion start and end.
          n.act = req.cfg;
          // single-shot powers down after its result.
          if (single) begin
            n.st = CV_IDLE;
          end
        end
      end
      default: begin
        n.st = CV_IDLE;
      end
    endcase
    // any reset returns to powered-down single-shot.
    if (reset || req.soft_rst) begin
      n.st = CV_IDLE;
      n.cnt = '0;
      n.act = CFG_DEF;
      n.res = '0;
      n.done = 1'h0;
    end
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    r <= n;
  end

  // Answer towards the serial side.
  assign rsp.busy = (r.st != CV_IDLE);
  assign rsp.done = r.done;
  assign rsp.result = r.res;
  assign rsp.act_cfg = r.act;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  wake_time_a: assert property ((r.st == CV_WAKE) |-> (r.cnt < CNT_W'(WAKE_CYC))) else $error("wake too long");
  os_ignore_a: assert property ((r.st == CV_CONV && req.os_req && !req.soft_rst && r.cnt != conv_last)
    |=> (r.st == CV_CONV && r.cnt != '0)) else $error("start accepted while busy");
  single_done_a: assert property ((r.st == CV_CONV && r.cnt == conv_last && single && !req.soft_rst)
    |=> (r.st == CV_IDLE && r.done)) else $error("no power-down after result");
  cont_next_a: assert property ((r.st == CV_CONV && r.cnt == conv_last && !single && !req.soft_rst)
    |=> (r.st == CV_CONV && r.cnt == '0 && r.done)) else $error("continuous chain broken");
  soft_pd_a: assert property (req.soft_rst |=> (r.st == CV_IDLE && r.act == CFG_DEF))
    else $error("soft reset not powered down");

endmodule

// File: adcmc_top.sv
// Two-wire slave with configuration word and conversion mode control.
// Summary of operation
// - Power-up reset loads the configuration word with its default value.
// - After reset the block idles powered down; bus logic keeps working.
// - General-call command 06h performs the same reset as power-up.
// - Mode bit 1 selects single-shot, powered down, still answering bus traffic.
// - Writing the start flag wakes for 25 us, flag reads 0, one conversion.
// - After a single-shot result the converter powers down by itself.
// - A start flag write during a conversion is ignored.
// - Mode bit 0 converts back to back, storing each result.
// - New settings apply from the next conversion; the running one keeps old ones.
// - Writing mode 1 or any reset leaves continuous mode.
// - Slave only; the clock line is never driven.
// - Lines are only pulled low; an undriven line reads high.
// - Data changes while clock low, sampled on clock high, eight-bit groups.
// - Data fall with clock high is start, data rise is stop.
// - Bus stuck for more than 25 ms counts as timed out.
// - Address byte is seven address bits plus direction; answer own address and the general-call address only.
// - Eight bits addressed here are acknowledged by pulling data low on ninth pulse.
// - Not-acknowledge leaves data high; an unaddressed slave never pulls it.
// - Stop returns to idle; a start while active is a repeated start.
// - General-call address accepted only for writes, acknowledged, next byte a command.
// - Each conversion lasts exactly one output-data period.
// - Write: pointer byte, then two bytes high first, each acknowledged.
`timescale 1ns/1ps
module adcmc_top import adcmc_pkg::*; #(
  parameter int unsigned TOUT_CYC = TOUT_CYC_DEF,
  parameter int unsigned CONV_CYC [RATES] = CONV_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] dev_addr,
  input wire logic [RES_W-1:0] conv_data,
  output logic analog_on,
  output logic [15:0] conv_cfg,
  output logic result_ready,
  output logic bus_timeout
);

  // ****************************************************************
  // State of the serial slave
  // ****************************************************************
  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic [6:0] adr1;
    logic [6:0] adr2;
    adcmc_sl_e st;
    logic mack_ph;
    logic [3:0] bits;
    logic [7:0] sh;
    logic rw;
    logic gc;
    logic [1:0] ptr;
    logic [1:0] bidx;
    logic [7:0] msb;
    logic [15:0] cfg;
    logic [15:0] txw;
    logic txlo;
    logic oe;
    logic mack;
    logic [CNT_W-1:0] idle;
    logic tout;
    logic os_req;
    logic gc_rst;
  } adcmc_sl_s;

  adcmc_sl_s r;
  adcmc_sl_s n;
  adcmc_req_s req;
  adcmc_rsp_s rsp;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic edge_any;
  logic tout_hit;
  logic [15:0] rd_word;
  logic [15:0] wr_word;

  // Refuse a timeout the idle counter cannot reach.
  if (TOUT_CYC < 2 || TOUT_CYC >= (1 << CNT_W)) begin : g_tout_chk
    $error("timeout count out of range");
  end

  // ****************************************************************
  // Bus line events
  // ****************************************************************
  // Edges and conditions seen on the synchronised lines.
  assign rise = r.scl2 & ~r.scl3;
  assign fall = ~r.scl2 & r.scl3;
  // data edges while clock high mark start and stop.
  assign start = r.scl2 & r.scl3 & r.sda3 & ~r.sda2;
  assign stop = r.scl2 & r.scl3 & ~r.sda3 & r.sda2;
  assign edge_any = (r.scl2 ^ r.scl3) | (r.sda2 ^ r.sda3);
  // bus stalled mid-transfer for longer than the limit.
  assign tout_hit = (r.st != SL_IDLE) && (r.idle == CNT_W'(TOUT_CYC - 1)) && !edge_any;

  // Word sent on a read; the start flag reads 0 while converting.
  always_comb begin
    rd_word = '0;
    if (r.ptr == PTR_CONV) begin
      rd_word = rsp.result;
    end else if (r.ptr == PTR_CFG) begin
      rd_word = r.cfg;
      // flag shows 0 from wake-up until power-down.
      rd_word[CFG_OS] = ~rsp.busy;
    end
  end

  // data bytes pair high byte first.
  assign wr_word = {r.msb, r.sh};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    n = r;
    n.os_req = 1'h0;
    n.gc_rst = 1'h0;
    n.tout = 1'h0;
    n.scl1 = scl_in;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = sda_in;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
    n.adr1 = dev_addr;
    n.adr2 = r.adr1;
    n.idle = (edge_any || r.st == SL_IDLE) ? '0 : r.idle + 1'h1;

    // Byte-level slave sequence.
    case (r.st)
      SL_IDLE: begin
        n.oe = 1'h0;
      end
      SL_ADDR: begin
        // sample on clock rise, eight bits per byte.
        if (rise) begin
          n.sh = {r.sh[6:0], r.sda2};
          n.bits = r.bits + 1'h1;
        end
        if (fall && r.bits == BYTE_BITS) begin
          n.bits = '0;
          n.bidx = '0;
          n.rw = r.sh[0];
          n.txw = rd_word;
          n.txlo = 1'h0;
          if (r.sh[7:1] == r.adr2) begin
            n.gc = 1'h0;
            // pull data low for the ninth pulse.
            n.oe = 1'h1;
            n.st = SL_ACK;
          // general call only with direction bit 0.
          end else if (r.sh[7:1] == GC_ADDR && !r.sh[0]) begin
            n.gc = 1'h1;
            n.oe = 1'h1;
            n.st = SL_ACK;
          end else begin
            n.st = SL_IDLE;
          end
        end
      end
      SL_ACK: begin
        if (fall) begin
          n.bits = '0;
          if (r.rw) begin
            // first bit set while clock low.
            n.sh = r.txw[15:8];
            n.oe = ~r.txw[15];
            n.mack_ph = 1'h0;
            n.st = SL_TX;
          end else begin
            n.oe = 1'h0;
            n.st = SL_RX;
          end
        end
      end
      SL_RX: begin
        if (rise) begin
          n.sh = {r.sh[6:0], r.sda2};
          n.bits = r.bits + 1'h1;
        end
        if (fall && r.bits == BYTE_BITS) begin
          n.bits = '0;
          n.oe = 1'h1;
          n.st = SL_ACK;
          if (r.gc) begin
            n.gc_rst = (r.sh == GC_RST_CMD);
          end else begin
            n.bidx = (r.bidx == 2'h3) ? r.bidx : r.bidx + 1'h1;
            if (r.bidx == 2'h0) begin
              n.ptr = r.sh[1:0];
            end else if (r.bidx == 2'h1) begin
              n.msb = r.sh;
            end else if (r.bidx == 2'h2 && r.ptr == PTR_CFG) begin
              n.cfg = wr_word;
              n.cfg[CFG_OS] = 1'h0;
              // the sequencer drops this if already busy.
              n.os_req = wr_word[CFG_OS];
            end
          end
        end
      end
      SL_TX: begin
        if (!r.mack_ph) begin
          if (rise) begin
            n.bits = r.bits + 1'h1;
          end
          if (fall) begin
            if (r.bits == BYTE_BITS) begin
              n.oe = 1'h0;
              n.mack = 1'h0;
              n.mack_ph = 1'h1;
            end else begin
              n.sh = {r.sh[6:0], 1'h0};
              n.oe = ~r.sh[6];
            end
          end
        end else begin
          // master acknowledge sampled on its clock pulse.
          if (rise) begin
            n.mack = ~r.sda2;
          end
          if (fall) begin
            n.bits = '0;
            n.mack_ph = 1'h0;
            n.txlo = ~r.txlo;
            n.sh = r.txlo ? r.txw[15:8] : r.txw[7:0];
            n.oe = r.txlo ? ~r.txw[15] : ~r.txw[7];
            // a master not-acknowledge ends the read.
            if (!r.mack) begin
              n.oe = 1'h0;
              n.st = SL_IDLE;
            end
          end
        end
      end
      default: begin
        n.st = SL_IDLE;
        n.oe = 1'h0;
      end
    endcase

    // timeout drops the transfer and releases data.
    if (tout_hit) begin
      n.tout = 1'h1;
      n.st = SL_IDLE;
      n.oe = 1'h0;
    end
    // stop to idle, start also when repeated.
    if (stop) begin
      n.st = SL_IDLE;
      n.oe = 1'h0;
    end
    if (start) begin
      n.st = SL_ADDR;
      n.bits = '0;
      n.oe = 1'h0;
    end
    if (r.gc_rst) begin
      n.cfg = CFG_DEF;
      n.ptr = PTR_CONV;
    end
    if (reset) begin
      n = '0;
      n.scl1 = 1'h1;
      n.scl2 = 1'h1;
      n.scl3 = 1'h1;
      n.sda1 = 1'h1;
      n.sda2 = 1'h1;
      n.sda3 = 1'h1;
      n.st = SL_IDLE;
      n.cfg = CFG_DEF;
    end
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    r <= n;
  end

  // ****************************************************************
  // Conversion sequencer and outputs
  // ****************************************************************
  // Requests towards the sequencer.
  assign req.soft_rst = r.gc_rst;
  assign req.os_req = r.os_req;
  assign req.cfg = r.cfg;

  adcmc_conv #(
    .CONV_CYC(CONV_CYC)
  ) u_conv (
    .ref_clk(ref_clk),
    .reset(reset),
    .req(req),
    .conv_data(conv_data),
    .rsp(rsp)
  );

  // open drain, only ever driving low; clock never driven.
  assign sda_out = 1'h0;
  assign sda_oe = r.oe;
  assign analog_on = rsp.busy;
  assign conv_cfg = rsp.act_cfg;
  assign result_ready = rsp.done;
  assign bus_timeout = r.tout;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  idle_quiet_a: assert property ((r.st == SL_IDLE) |-> !r.oe) else $error("data pulled while idle");
  start_addr_a: assert property (start |=> (r.st == SL_ADDR && !r.oe && r.bits == '0))
    else $error("start not taken");
  stop_idle_a: assert property ((stop && !start) |=> (r.st == SL_IDLE)) else $error("stop not taken");
  addr_ack_a: assert property ((r.st == SL_ADDR && fall && r.bits == BYTE_BITS && r.sh[7:1] == r.adr2
    && !tout_hit) |=> (r.st == SL_ACK && r.oe)) else $error("own address not acknowledged");
  gc_read_a: assert property ((r.st == SL_ADDR && fall && r.bits == BYTE_BITS && r.sh == {GC_ADDR, 1'h1}
    && r.adr2 != GC_ADDR) |=> (r.st == SL_IDLE && !r.oe)) else $error("general call read accepted");
  tout_drop_a: assert property (tout_hit |=> (r.tout && r.st == SL_IDLE && !r.oe))
    else $error("timeout did not abort");
  gc_cfg_a: assert property (r.gc_rst |=> (r.cfg == CFG_DEF && r.ptr == PTR_CONV))
    else $error("general call reset missed");
  por_cfg_a: assert property ($fell(reset) |-> (r.cfg == CFG_DEF && !analog_on))
    else $error("reset defaults wrong");

endmodule

// File: adcmc_bus_master.sv
// Behavioural two-wire bus master that clocks the bus and pulls data low.
`timescale 1ns/1ps
module adcmc_bus_master (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // ****************************************************************
  // Line levels
  // ****************************************************************
  // Both lines start released, so the bus idles high.
  // master owns clock
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ****************************************************************
  // Conditions and bits
  // ****************************************************************
  // Waits out the slave release before raising the clock, then falls data.
  // start condition
  task automatic start_c();
    sda_pull = 1'b0;
    #100;
    scl = 1'b1;
    #75;
    sda_pull = 1'b1;
    #75;
    scl = 1'b0;
  endtask

  // Raises data while the clock is high to end the transfer.
  // stop condition
  task automatic stop_c();
    #50;
    sda_pull = 1'b1;
    #75;
    scl = 1'b1;
    #75;
    sda_pull = 1'b0;
    #100;
  endtask

  // Sets data in the low phase and samples it late in the high phase.
  // bit timing
  task automatic bit_io(input logic b, output logic r);
    #50;
    sda_pull = !b;
    #75;
    scl = 1'b1;
    #70;
    r = sda;
    #5;
    scl = 1'b0;
  endtask

  // Moves eight data bits and the acknowledge bit, most significant first.
  // tx[0] drives the ninth bit, so the caller picks master ack or not-ack on reads
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the converter mode control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module testbench import adcmc_pkg::*;;
  localparam logic [6:0] DEV = 7'h48;
  localparam int TOUT = 2000;
  localparam int unsigned CCYC [RATES] = '{400, 300, 250, 200, 150, 120, 100, 100};
  // Cycles from a start request to its result, less the bus tail that follows the request.
  localparam int SHOT = int'(WAKE_CYC + CCYC[4]) - 17;
  logic ref_clk;
  logic reset;
  logic scl;
  logic m_pull;
  logic sda_w;
  logic sda_out;
  logic sda_oe;
  logic [11:0] conv_data;
  logic analog_on;
  logic [15:0] conv_cfg;
  logic result_ready;
  logic bus_timeout;
  logic oe_seen;
  int rr_cnt;
  int mismatches;
  int cmp_count;

  // ****************************************************************
  // Structure
  // ****************************************************************
  // wired low wins
  assign sda_w = !(m_pull || (sda_oe && !sda_out));

  adcmc_top #(.TOUT_CYC(TOUT), .CONV_CYC(CCYC)) dut (
    .ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_addr(DEV), .conv_data(conv_data), .analog_on(analog_on),
    .conv_cfg(conv_cfg), .result_ready(result_ready), .bus_timeout(bus_timeout));

  adcmc_bus_master master (.scl(scl), .sda_pull(m_pull), .sda(sda_w));

  // The clock toggles every half period.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Records any data pull and counts stored results.
  always @(posedge ref_clk) begin
    if (sda_oe === 1'b1) oe_seen <= 1'b1;
    if (result_ready === 1'b1) rr_cnt <= rr_cnt + 1;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Waits a number of falling edges.
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Counts cycles up to the next result pulse, bounded by lim.
  task automatic wait_rr(input int lim, output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (result_ready !== 1'b1 && n < lim);
    `CHK("result_ready", 1'b1, result_ready)
  endtask

  // Sends one byte and checks the slave answer.
  task automatic send(input logic [7:0] b, input logic ack);
    logic [8:0] rx;
    master.xfer({b, 1'b1}, rx);
    `CHK("ack", ack, !rx[0])
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    master.start_c();
    send({DEV, 1'b0}, 1'b1);
    send(p, 1'b1);
    send(v[15:8], 1'b1);
    send(v[7:0], 1'b1);
    master.stop_c();
    @(negedge ref_clk);
  endtask

  // Sets the pointer, then reads the word after a repeated start.
  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    logic [8:0] rx;
    master.start_c();
    send({DEV, 1'b0}, 1'b1);
    send(p, 1'b1);
    master.start_c();
    send({DEV, 1'b1}, 1'b1);
    master.xfer(9'h1FE, rx);
    v[15:8] = rx[8:1];
    master.xfer(9'h1FF, rx);
    v[7:0] = rx[8:1];
    master.stop_c();
    @(negedge ref_clk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Checks defaults after reset and that bus traffic leaves power-down alone.
  task automatic t_reset();
    logic [15:0] v;
    `CHK("conv_cfg", 16'h8583, conv_cfg)
    rd(8'h01, v);
    `CHK("cfg read", 16'h8583, v)
    rd(8'h00, v);
    `CHK("result read", 16'h0000, v)
    `CHK("analog_on", 1'b0, analog_on)
  endtask

  // Foreign address and a general-call read are both left unanswered.
  task automatic t_addr();
    oe_seen = 1'b0;
    master.start_c();
    send({7'h49, 1'b0}, 1'b0);
    master.stop_c();
    master.start_c();
    send({GC_ADDR, 1'b1}, 1'b0);
    master.stop_c();
    @(negedge ref_clk);
    `CHK("sda_oe seen", 1'b0, oe_seen)
  endtask

  // Single shot with a busy read and an ignored restart, then a second shot.
  task automatic t_single();
    int n;
    int c0;
    logic [15:0] v;
    conv_data = 12'hA5C;
    wr(8'h01, 16'h8583);
    c0 = rr_cnt;
    fork
      wait_rr(3000, n);
      begin
        rd(8'h01, v);
        `CHK("busy flag", 16'h0583, v)
        wr(8'h01, 16'h8583);
      end
    join
    `CHK("shot time", 1'b1, (n >= SHOT - 6 && n <= SHOT + 6))
    cyc(5);
    `CHK("powered down", 1'b0, analog_on)
    cyc(1500);
    `CHK("one result", c0 + 1, rr_cnt)
    rd(8'h00, v);
    `CHK("result", {12'hA5C, 4'h0}, v)
    wr(8'h01, 16'h8583);
    wait_rr(3000, n);
    `CHK("second shot", 1'b1, (n >= SHOT - 6 && n <= SHOT + 6))
  endtask

  // Continuous conversion, a rate change, and leaving by mode bit.
  task automatic t_cont();
    int n;
    int c0;
    wr(8'h01, 16'h8483);
    wait_rr(3000, n);
    wait_rr(1000, n);
    `CHK("period", int'(CCYC[4]), n)
    wr(8'h01, 16'h84E3);
    wait_rr(200, n);
    `CHK("new cfg", 16'h04E3, conv_cfg)
    wait_rr(200, n);
    `CHK("new period", int'(CCYC[7]), n)
    // Delays the write so the running conversion ends after the bench starts waiting.
    cyc(20);
    wr(8'h01, 16'h0583);
    wait_rr(200, n);
    cyc(5);
    c0 = rr_cnt;
    `CHK("left cont", 1'b0, analog_on)
    cyc(600);
    `CHK("no results", c0, rr_cnt)
  endtask

  // General-call reset in mid conversion returns to defaults.
  task automatic t_gc();
    logic [15:0] v;
    wr(8'h01, 16'h8483);
    cyc(1200);
    `CHK("running", 1'b1, analog_on)
    master.start_c();
    send({GC_ADDR, 1'b0}, 1'b1);
    send(GC_RST_CMD, 1'b1);
    master.stop_c();
    cyc(2);
    `CHK("gc cfg", 16'h8583, conv_cfg)
    `CHK("gc off", 1'b0, analog_on)
    rd(8'h01, v);
    `CHK("gc read", 16'h8583, v)
  endtask

  // A stalled address byte times out and the bus works again afterwards.
  task automatic t_tout();
    logic r;
    logic [15:0] v;
    int n;
    master.start_c();
    for (int i = 6; i >= 3; i--) begin
      master.bit_io(DEV[i], r);
    end
    n = 0;
    while (bus_timeout !== 1'b1 && n < TOUT + 100) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("timeout time", 1'b1, (n > TOUT - 40 && n < TOUT + 20))
    `CHK("released", 1'b0, sda_oe)
    master.stop_c();
    rd(8'h01, v);
    `CHK("after timeout", 16'h8583, v)
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Resets the block for ten cycles and runs every scenario.
  initial begin
    reset = 1'b1;
    conv_data = 12'h000;
    oe_seen = 1'b0;
    rr_cnt = 0;
    mismatches = 0;
    cmp_count = 0;
    cyc(10);
    reset = 1'b0;
    cyc(3);
    t_reset();
    t_addr();
    t_single();
    t_cont();
    t_gc();
    t_tout();
    test_done();
  end

  // Cuts a hang short well after the expected run length.
  initial begin
    #1_500_000;
    mismatches++;
    test_done();
  end
endmodule
